/* File: hdl/uep_ep0_ctrl.v */
`timescale 1ns/1ns
`include "uep_regs.vh"

module uep_ep0_ctrl (
    input wire i_clk,
    input wire i_rst_b,
    // avalon-mm slave
    input wire [3:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output reg [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    // controller role: high while acting as host
    input wire i_host_role,
    // packet engine events, one-cycle pulses
    input wire i_rx_pkt_arrived,
    input wire i_tx_pkt_sent,
    input wire i_stall_sent,
    input wire i_ctrl_xfer_end,
    // state toward the packet engine
    output wire o_tx_packet_loaded,
    output wire o_rx_packet_present,
    output wire o_stall_request,
    output wire o_last_data_flag,
    output reg o_fifo_discard,
    output reg o_ep0_irq,
    output wire [10:0] o_max_payload_size,
    output wire [3:0] o_endpoint_select,
    output wire o_host_toggle
);

    // ----------------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------------
    // one wait state per access gives time to register read data
    reg bus_ack;
    wire bus_req;
    wire bus_take;
    wire wr_take;

    assign bus_req = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = bus_req & ~bus_ack;
    assign bus_take = bus_req & bus_ack;
    assign wr_take = bus_take & i_avs_write;

    // ack toggles high on the second cycle of each request
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= bus_req & ~bus_ack;
        end
    end

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    reg [3:0] endpoint_select;
    reg [10:0] max_payload_size;
    reg [7:0] host_low;
    // host flush is write-only and not stored, so no bit 8 here
    reg host_toggle;
    wire sel_index;
    wire sel_maxp;
    wire sel_csr;
    wire ep0_seen;
    wire peri_wr;
    wire host_wr;
    wire [15:0] wdata;

    assign wdata = i_avs_writedata[15:0];
    assign ep0_seen = (endpoint_select == `UEP_EP0);
    assign sel_index = (i_avs_address == `UEP_OFS_INDEX);
    assign sel_maxp = (i_avs_address == `UEP_OFS_TX_MAX_PAYLOAD);
    assign sel_csr = (i_avs_address == `UEP_OFS_EP0_CSR) & ep0_seen;
    // role picks which layout a csr write lands in
    assign peri_wr = wr_take & sel_csr & ~i_host_role;
    assign host_wr = wr_take & sel_csr & i_host_role;

    // ----------------------------------------------------------------
    // index and payload registers
    // ----------------------------------------------------------------
    wire maxp_lo_wr;
    wire maxp_hi_wr;

    // lanes split so a byte write leaves the other half untouched
    assign maxp_lo_wr = wr_take & sel_maxp & i_avs_byteenable[0];
    assign maxp_hi_wr = wr_take & sel_maxp & i_avs_byteenable[1];

    // the payload value is trusted as written; a bad size is software's fault
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            endpoint_select <= `UEP_RST_ENDPOINT_SELECT;
            max_payload_size <= `UEP_RST_MAXP;
        end else begin
            if (wr_take && sel_index && i_avs_byteenable[0]) begin
                endpoint_select <= wdata[`UEP_ENDPOINT_SELECT_MSB:0];
            end
            if (maxp_lo_wr) begin
                max_payload_size[7:0] <= wdata[7:0];
            end
            if (maxp_hi_wr) begin
                max_payload_size[10:8] <= wdata[10:8];
            end
        end
    end

    assign o_endpoint_select = endpoint_select;
    assign o_max_payload_size = max_payload_size;

    // ----------------------------------------------------------------
    // software strobes on the peripheral layout
    // ----------------------------------------------------------------
    wire lo_wr;
    wire hi_wr;
    wire sw_discard;
    wire sw_setup_ack;
    wire sw_rx_ack;
    wire sw_stall_req;
    wire sw_last_data;
    wire sw_stall_sent_clr;
    wire sw_tx_load;

    assign lo_wr = peri_wr & i_avs_byteenable[0];
    assign hi_wr = peri_wr & i_avs_byteenable[1];
    assign sw_discard = hi_wr & wdata[`UEP_BIT_FIFO_DISCARD];
    assign sw_setup_ack = lo_wr & wdata[`UEP_BIT_SETUP_ABORT_ACK];
    assign sw_rx_ack = lo_wr & wdata[`UEP_BIT_RX_READY_ACK];
    assign sw_stall_req = lo_wr & wdata[`UEP_BIT_STALL_REQUEST];
    assign sw_last_data = lo_wr & wdata[`UEP_BIT_LAST_DATA_FLAG];
    // stall sent is read/write: a zero written clears it
    assign sw_stall_sent_clr = lo_wr & ~wdata[`UEP_BIT_STALL_SENT_FLAG];
    assign sw_tx_load = lo_wr & wdata[`UEP_BIT_TX_PACKET_LOADED];

    // ----------------------------------------------------------------
    // flush and early end
    // ----------------------------------------------------------------
    wire tx_packet_loaded;
    wire rx_packet_present;
    wire last_data_flag;
    wire early_end_event;
    wire flush_now;

    // a transfer that closes without the last data mark is an abort
    assign early_end_event = i_ctrl_xfer_end & ~last_data_flag;
    // a software flush has effect only while a packet is flagged ready; an early end flushes regardless
    assign flush_now = (sw_discard & (tx_packet_loaded | rx_packet_present))
        | early_end_event;

    // discard pulse resets the fifo pointer in the packet engine
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_fifo_discard <= 1'b0;
        end else begin
            o_fifo_discard <= flush_now;
        end
    end

    // ----------------------------------------------------------------
    // endpoint 0 flags
    // ----------------------------------------------------------------
    wire tx_loaded_clr;
    wire rx_present_clr;

    // flush empties both directions, so both ready flags drop together
    assign tx_loaded_clr = i_tx_pkt_sent | flush_now;
    assign rx_present_clr = sw_rx_ack | flush_now;

    // loaded: software sets, sent packet or flush clears
    uep_flag u_tx_loaded (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_set(sw_tx_load),
        .i_clr(tx_loaded_clr),
        .o_q(tx_packet_loaded)
    );

    // present: arrival sets, only acknowledge or flush clears
    uep_flag u_rx_present (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_set(i_rx_pkt_arrived),
        .i_clr(rx_present_clr),
        .o_q(rx_packet_present)
    );

    // stall request drops once the handshake has gone out
    uep_flag u_stall_req (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_set(sw_stall_req),
        .i_clr(i_stall_sent),
        .o_q(o_stall_request)
    );

    // last data mark lives until the transfer closes
    uep_flag u_last_data (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_set(sw_last_data),
        .i_clr(i_ctrl_xfer_end),
        .o_q(last_data_flag)
    );

    wire stall_sent_flag;
    uep_flag u_stall_sent (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_set(i_stall_sent),
        .i_clr(sw_stall_sent_clr),
        .o_q(stall_sent_flag)
    );

    wire early_control_end;
    uep_flag u_early_end (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_set(early_end_event),
        .i_clr(sw_setup_ack),
        .o_q(early_control_end)
    );

    assign o_tx_packet_loaded = tx_packet_loaded;
    assign o_rx_packet_present = rx_packet_present;
    assign o_last_data_flag = last_data_flag;

    // ----------------------------------------------------------------
    // interrupt event toward the controller
    // ----------------------------------------------------------------
    wire irq_tx_done;
    wire irq_rx_arrival;
    wire irq_early_end;

    // a sent packet interrupts only if software had marked it loaded
    assign irq_tx_done = i_tx_pkt_sent & tx_packet_loaded;
    assign irq_rx_arrival = i_rx_pkt_arrived;
    assign irq_early_end = early_end_event;

    // masking and status live in the controller's shared interrupt block
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_ep0_irq <= 1'b0;
        end else begin
            o_ep0_irq <= irq_tx_done | irq_rx_arrival | irq_early_end;
        end
    end

    // ----------------------------------------------------------------
    // host layout storage
    // ----------------------------------------------------------------
    // only plain storage here; host transaction behaviour sits elsewhere.
    // toggle bit takes a write only with its write enable in the same write
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            host_low <= `UEP_RST_HOST_LOW;
            host_toggle <= `UEP_RST_HOST_TOGGLE;
        end else begin
            if (host_wr && i_avs_byteenable[0]) begin
                host_low <= wdata[7:0];
            end
            if (host_wr && i_avs_byteenable[1] && wdata[`UEP_HBIT_TOGGLE_WREN]) begin
                host_toggle <= wdata[`UEP_HBIT_TOGGLE];
            end
        end
    end

    assign o_host_toggle = host_toggle;

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    // write-only strobe bits read zero; reserved bits read zero
    reg [15:0] next_rd;
    always @* begin
        next_rd = 16'h0000;
        if (sel_index) begin
            next_rd[`UEP_ENDPOINT_SELECT_MSB:0] = endpoint_select;
        end else if (sel_maxp) begin
            next_rd[`UEP_MAXP_MSB:0] = max_payload_size;
        end else if (sel_csr && i_host_role) begin
            next_rd[7:0] = host_low;
            next_rd[`UEP_HBIT_TOGGLE] = host_toggle;
        end else if (sel_csr) begin
            next_rd[`UEP_BIT_EARLY_CONTROL_END] = early_control_end;
            next_rd[`UEP_BIT_STALL_SENT_FLAG] = stall_sent_flag;
            next_rd[`UEP_BIT_TX_PACKET_LOADED] = tx_packet_loaded;
            next_rd[`UEP_BIT_RX_PACKET_PRESENT] = rx_packet_present;
        end
    end

    wire rd_capture;

    // sampled in the wait cycle only, so a held read is not captured twice
    assign rd_capture = i_avs_read & ~bus_ack;

    // captured in the wait cycle, stands at the accepting edge
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_avs_readdata <= 32'h00000000;
        end else if (rd_capture) begin
            o_avs_readdata <= {16'h0000, next_rd};
        end
    end

endmodule // uep_ep0_ctrl

/* File: hdl/uep_regs.vh */
`ifndef UEP_REGS_VH
`define UEP_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define UEP_OFS_INDEX 4'h0
`define UEP_OFS_TX_MAX_PAYLOAD 4'h4
`define UEP_OFS_EP0_CSR 4'h8

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UEP_ENDPOINT_SELECT_MSB 3
`define UEP_MAXP_MSB 10
`define UEP_BIT_FIFO_DISCARD 8
`define UEP_BIT_SETUP_ABORT_ACK 7
`define UEP_BIT_RX_READY_ACK 6
`define UEP_BIT_STALL_REQUEST 5
`define UEP_BIT_EARLY_CONTROL_END 4
`define UEP_BIT_LAST_DATA_FLAG 3
`define UEP_BIT_STALL_SENT_FLAG 2
`define UEP_BIT_TX_PACKET_LOADED 1
`define UEP_BIT_RX_PACKET_PRESENT 0
`define UEP_HBIT_TOGGLE_WREN 10
`define UEP_HBIT_TOGGLE 9

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define UEP_RST_ENDPOINT_SELECT 4'h0
`define UEP_RST_MAXP 11'h000
`define UEP_RST_HOST_LOW 8'h00
`define UEP_RST_HOST_TOGGLE 1'h0
`define UEP_EP0 4'h0

`endif

/* File: hdl/uep_flag.v */
`timescale 1ns/1ns
// sticky flag: a set in the same cycle as a clear wins
module uep_flag (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_set,
    input wire i_clr,
    output reg o_q
);

    // ----------------------------------------------------------------
    // flag storage
    // ----------------------------------------------------------------
    // set checked first so an event is never lost to a clear
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_q <= 1'b0;
        end else if (i_set) begin
            o_q <= 1'b1;
        end else if (i_clr) begin
            o_q <= 1'b0;
        end
    end

endmodule // uep_flag

/* File: dv/uep_ep0_ctrl_assertions.sv */
`timescale 1ns/1ns
// ----
// endpoint 0 flag checker
// ----
module uep_ep0_ctrl_chk (
    input logic i_clk,
    input logic i_rst_b,
    input logic i_avs_read,
    input logic i_avs_write,
    input logic o_avs_waitrequest,
    input logic i_rx_pkt_arrived,
    input logic i_tx_pkt_sent,
    input logic i_stall_sent,
    input logic i_ctrl_xfer_end,
    input logic o_tx_packet_loaded,
    input logic o_rx_packet_present,
    input logic o_stall_request,
    input logic o_last_data_flag,
    input logic o_fifo_discard,
    input logic o_ep0_irq
);
    // one clock domain, so one default for all
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    property p_rx; i_rx_pkt_arrived |=> o_rx_packet_present && o_ep0_irq; endproperty
    a_rx: assert property (p_rx) else $error("rx arrival not flagged");
    property p_stall; i_stall_sent |=> !o_stall_request; endproperty
    a_stall: assert property (p_stall) else $error("stall request kept");
    property p_tx; i_tx_pkt_sent && o_tx_packet_loaded |=> o_ep0_irq && !o_tx_packet_loaded;
    endproperty
    a_tx: assert property (p_tx) else $error("tx done not handled");
    property p_early; i_ctrl_xfer_end && !o_last_data_flag |=> o_fifo_discard && o_ep0_irq;
    endproperty
    a_early: assert property (p_early) else $error("early end not handled");
    property p_ld; i_ctrl_xfer_end |=> !o_last_data_flag; endproperty
    a_ld: assert property (p_ld) else $error("last data kept");
    property p_wait; $rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("bus wait state wrong");
    // discard from software only when something was pending
    property p_disc; o_fifo_discard && !$past(i_ctrl_xfer_end)
        |-> $past(o_tx_packet_loaded || o_rx_packet_present); endproperty
    a_disc: assert property (p_disc) else $error("discard with nothing pending");
    property p_rxfell; $fell(o_rx_packet_present) |-> $past(i_avs_write) || $past(i_ctrl_xfer_end);
    endproperty
    a_rxfell: assert property (p_rxfell) else $error("rx flag lost");
endmodule // uep_ep0_ctrl_chk
bind uep_ep0_ctrl uep_ep0_ctrl_chk chk_u (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
    .i_rx_pkt_arrived(i_rx_pkt_arrived), .i_tx_pkt_sent(i_tx_pkt_sent),
    .i_stall_sent(i_stall_sent), .i_ctrl_xfer_end(i_ctrl_xfer_end),
    .o_tx_packet_loaded(o_tx_packet_loaded), .o_rx_packet_present(o_rx_packet_present),
    .o_stall_request(o_stall_request), .o_last_data_flag(o_last_data_flag),
    .o_fifo_discard(o_fifo_discard), .o_ep0_irq(o_ep0_irq));

/* File: dv/uep_host_model.sv */
`timescale 1ns/1ns
// ----
// far-side packet engine model
// ----
module uep_host_model (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_slow,
    input wire i_tx_packet_loaded,
    input wire i_stall_request,
    output reg o_tx_pkt_sent = 1'b0,
    output reg o_stall_sent = 1'b0
);
    reg [2:0] cnt;
    // answers after 0 or 5 cycles; slow mode proves flags hold while waiting
    always @(posedge i_clk) begin
        o_tx_pkt_sent <= 1'b0;
        o_stall_sent <= 1'b0;
        if (!i_rst_b || !(i_tx_packet_loaded || i_stall_request) || o_tx_pkt_sent || o_stall_sent) begin
            cnt <= 3'h0;
        end else if (cnt == (i_slow ? 3'h5 : 3'h0)) begin
            o_stall_sent <= i_stall_request;
            o_tx_pkt_sent <= !i_stall_request;
            cnt <= 3'h0;
        end else begin
            cnt <= cnt + 3'h1;
        end
    end
endmodule // uep_host_model

/* File: dv/usb_ep0_control_status_bench.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module usb_ep0_control_status_bench;
    reg i_clk = 1'b0;
    reg i_rst_b = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0, wr = 1'b0, host = 1'b0, slow = 1'b1;
    logic [15:0] wd = 16'h0000;
    logic [3:0] be = 4'h3;
    logic [1:0] ev_v = 2'h0; // bit0 rx arrival, bit1 transfer end
    logic [31:0] q;
    wire [31:0] rdata;
    wire [3:0] esel;
    wire [10:0] maxp;
    wire wait_r, tx_ld, rx_pr, st_rq, ld, disc, irq, tx_sent, st_sent, tog;
    int num_errors = 0, tests_run = 0, cyc = 0, disc_n = 0, irq_n = 0;
    // rows: address, write value, expected read
    // payload values stay within legal packet sizes; high bits probe the reserved field
    logic [35:0] rows [6] = '{{4'h4, 16'hF840, 16'h0040}, {4'h0, 16'h0003, 16'h0003},
        {4'h8, 16'h0002, 16'h0000}, {4'hC, 16'h1234, 16'h0000},
        {4'h0, 16'h0000, 16'h0000}, {4'h4, 16'h0400, 16'h0400}};
    always #25 i_clk = ~i_clk;
    uep_ep0_ctrl dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata({16'h0000, wd}), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_r), .i_host_role(host),
        .i_rx_pkt_arrived(ev_v[0]), .i_tx_pkt_sent(tx_sent), .i_stall_sent(st_sent),
        .i_ctrl_xfer_end(ev_v[1]), .o_tx_packet_loaded(tx_ld), .o_rx_packet_present(rx_pr),
        .o_stall_request(st_rq), .o_last_data_flag(ld), .o_fifo_discard(disc), .o_ep0_irq(irq),
        .o_max_payload_size(maxp), .o_endpoint_select(esel), .o_host_toggle(tog));
    uep_host_model peer_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_slow(slow),
        .i_tx_packet_loaded(tx_ld), .i_stall_request(st_rq), .o_tx_pkt_sent(tx_sent),
        .o_stall_sent(st_sent));
    // pulse counters and watchdog; a hang ends as a failure
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        disc_n <= disc_n + disc;
        irq_n <= irq_n + irq;
        if (cyc == 3000) begin
            num_errors++;
            give_verdict;
        end
    end
    task give_verdict;
        if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // one avalon transfer, held until waitrequest is seen low
    task bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk);
        wr <= w;
        rd <= !w;
        adr <= a;
        wd <= d;
        do @(posedge i_clk); while (wait_r !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task ev(input int k);
        @(posedge i_clk);
        ev_v[k] <= 1'b1;
        @(posedge i_clk);
        ev_v[k] <= 1'b0;
    endtask
    initial begin
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, rows[i][35:32], rows[i][31:16]);
            bus(1'b0, rows[i][35:32], 16'h0000);
            `CHK(q, {16'h0000, rows[i][15:0]})
        end
        `CHK(maxp, 11'h400)
        `CHK(esel, 4'h0)
        bus(1'b1, 4'h8, 16'h0002);
        bus(1'b0, 4'h8, 16'h0000);
        `CHK(q, 32'h0000_0002)
        repeat (8) @(posedge i_clk);
        bus(1'b0, 4'h8, 16'h0000);
        `CHK(q, 32'h0000_0000)
        `CHK(irq_n, 1)
        ev(0);
        bus(1'b0, 4'h8, 16'h0000);
        `CHK(q, 32'h0000_0001)
        bus(1'b1, 4'h8, 16'h0040);
        bus(1'b0, 4'h8, 16'h0000);
        `CHK(q, 32'h0000_0000)
        ev(0);
        bus(1'b1, 4'h8, 16'h0100);
        bus(1'b0, 4'h8, 16'h0000);
        `CHK(q, 32'h0000_0000)
        bus(1'b1, 4'h8, 16'h0100);
        bus(1'b0, 4'h8, 16'h0000);
        `CHK(disc_n, 1)
        `CHK(irq_n, 3)
        bus(1'b1, 4'h8, 16'h0020);
        repeat (8) @(posedge i_clk);
        bus(1'b0, 4'h8, 16'h0000);
        `CHK(q, 32'h0000_0004)
        `CHK(st_rq, 1'b0)
        bus(1'b1, 4'h8, 16'h0000);
        bus(1'b0, 4'h8, 16'h0000);
        `CHK(q, 32'h0000_0000)
        ev(1);
        bus(1'b0, 4'h8, 16'h0000);
        `CHK(q, 32'h0000_0010)
        `CHK(disc_n, 2)
        `CHK(irq_n, 4)
        bus(1'b1, 4'h8, 16'h0080);
        bus(1'b0, 4'h8, 16'h0000);
        `CHK(q, 32'h0000_0000)
        slow <= 1'b0;
        bus(1'b1, 4'h8, 16'h000A);
        @(posedge i_clk);
        `CHK(ld, 1'b1)
        ev(1);
        bus(1'b0, 4'h8, 16'h0000);
        `CHK(q, 32'h0000_0000)
        `CHK(ld, 1'b0)
        `CHK(irq_n, 5)
        host <= 1'b1;
        bus(1'b1, 4'h8, 16'h06FD);
        bus(1'b0, 4'h8, 16'h0000);
        `CHK(q, 32'h0000_02FD)
        `CHK(tog, 1'b1)
        i_rst_b <= 1'b0;
        @(posedge i_clk);
        i_rst_b <= 1'b1;
        bus(1'b0, 4'h4, 16'h0000);
        `CHK(q, 32'h0000_0000)
        `CHK(tog, 1'b0)
        be <= 4'h1;
        bus(1'b1, 4'h4, 16'hFF12);
        bus(1'b0, 4'h4, 16'h0000);
        `CHK(q, 32'h0000_0012)
        give_verdict;
    end
endmodule // usb_ep0_control_status_bench
